//--- dmc_pkg.sv
package dmc_pkg;
    // serial control word layout
    localparam int        WORD_BITS      = 16;
    localparam int        RW_POS         = 15;
    localparam int        IDX_MSB        = 14;
    localparam int        IDX_LSB        = 8;
    // frame bit counter marks on the link side
    localparam logic [4:0] FRAME_CMD_LAST  = 5'h07;
    localparam logic [4:0] FRAME_WORD_LAST = 5'h0F;
    localparam logic [4:0] FRAME_DATA_FIRST = 5'h08;
    localparam logic [4:0] FRAME_DONE      = 5'h10;
    // register indices
    localparam logic [6:0] IDX_FIRST      = 7'h01;
    localparam logic [6:0] IDX_LAST       = 7'h0C;
    localparam int         IDX_MUTE       = 7;
    localparam int         IDX_OFF        = 8;
    localparam int         IDX_FORMAT     = 9;
    localparam int         IDX_DEEMPH     = 10;
    localparam int         IDX_READBACK   = 11;
    localparam int         IDX_GPIO       = 12;
    localparam int         NUM_REGS       = 12;
    localparam int         NUM_CH         = 6;
    // values after reset
    localparam logic [7:0] ATTEN_RESET    = 8'hFF;
    localparam logic [7:0] ZERO_RESET     = 8'h00;
    localparam logic [7:0] READBACK_RESET = 8'h01;
    // attenuator codes at and below this one are infinite attenuation
    localparam logic [7:0] MUTE_CODE      = 8'h80;
    // last sample counter value before an attenuator step
    localparam logic [2:0] RAMP_LAST_FS   = 3'h7;
    // field positions
    localparam int FLT_POS  = 5;
    localparam int CLOCK_OUT_DIVIDE_POS = 4;
    localparam int CLOCK_OUT_DISABLE_POS = 3;
    localparam int ZERO_FLAG_POLARITY_POS = 6;
    localparam int OUTPUT_PHASE_INVERT_POS = 5;
    localparam int DMF_MSB  = 4;
    localparam int DMF_LSB  = 3;
    localparam int DMC_MSB  = 2;
    localparam int INC_POS  = 7;
    localparam int OVER_POS = 7;
    localparam int GENERAL_OUTPUT_ENABLE_POS = 6;
    // audio format codes
    typedef enum logic [2:0] {
        DMC_FMT_RJ24 = 3'h0, DMC_FMT_RJ20 = 3'h1, DMC_FMT_RJ18 = 3'h2, DMC_FMT_RJ16 = 3'h3,
        DMC_FMT_I2S  = 3'h4, DMC_FMT_LJ   = 3'h5, DMC_FMT_RSV6 = 3'h6, DMC_FMT_RSV7 = 3'h7
    } dmc_format_t;
endpackage

//--- dmc_ramp.sv
`timescale 1ns/1ps
module dmc_ramp (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // step strobe and clamped target code
    input  wire logic       step,
    input  wire logic [7:0] target,
    // applied attenuator state
    output logic      [7:0] level,
    output logic            silent
);
    import dmc_pkg::*;

    typedef struct packed {
        logic [7:0] level;
        logic       silent;
    } dmc_ramp_t;

    dmc_ramp_t s;
    dmc_ramp_t next_s;

    // one 0.5 dB code per step, toward the target in either direction
    always_comb begin
        next_s = s;
        if (step) begin
            if (s.level < target) begin
                next_s.level = s.level + 8'h01;
            end else if (s.level > target) begin
                next_s.level = s.level - 8'h01;
            end
        end
        next_s.silent = (next_s.level <= MUTE_CODE);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '{level: ATTEN_RESET, silent: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign level  = s.level;
    assign silent = s.silent;
endmodule // dmc_ramp

//--- dmc_link.sv
`timescale 1ns/1ps
module dmc_link (
    // link clock, frame and reset
    input  wire logic        mc_clk,
    input  wire logic        ml,
    input  wire logic        rst_b,
    // serial data pins
    input  wire logic        mdi,
    output logic             mdo,
    output logic             mdo_oe,
    // crossing to the register side
    input  wire logic [7:0]  rd_byte,
    output logic      [15:0] wr_word,
    output logic             wr_tog,
    output logic             rd_tog
);
    import dmc_pkg::*;

    typedef struct packed {
        logic [4:0]  cnt;
        logic [14:0] sh;
        logic        rd_mode;
        logic [7:0]  out_sh;
    } dmc_frame_t;

    typedef struct packed {
        logic [15:0] word;
        logic        wr_tog;
        logic        rd_tog;
    } dmc_keep_t;

    dmc_frame_t f;
    dmc_frame_t next_f;
    dmc_keep_t  k;
    dmc_keep_t  next_k;
    logic       frame_rst_b;

    // the clock may stop after a frame, so the frame's own latch line ends it
    assign frame_rst_b = rst_b & ~ml;

    // shift in on each rising edge; words and read requests leave by toggle
    always_comb begin
        next_f        = f;
        next_k        = k;
        next_f.sh     = {f.sh[13:0], mdi};
        next_f.out_sh = {f.out_sh[6:0], 1'b0};
        if (f.cnt < FRAME_DONE) begin
            next_f.cnt = f.cnt + 5'h01;
        end
        if (f.cnt == FRAME_CMD_LAST && f.sh[6]) begin
            next_f.rd_mode = 1'b1;
            next_f.out_sh  = rd_byte;
            next_k.rd_tog  = ~k.rd_tog;
        end
        if (f.rd_mode && f.cnt == FRAME_WORD_LAST) begin
            next_f.out_sh = rd_byte;
            next_k.rd_tog = ~k.rd_tog;
            next_f.cnt    = FRAME_DATA_FIRST;
        end
        if (!f.rd_mode && f.cnt == FRAME_WORD_LAST && !f.sh[14]) begin
            next_k.word   = {f.sh, mdi};
            next_k.wr_tog = ~k.wr_tog;
        end
    end

    // frame state, cleared whenever the latch line is high
    always_ff @(posedge mc_clk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    // handed-over words and toggles outlive the frame
    always_ff @(posedge mc_clk or negedge rst_b) begin
        if (!rst_b) begin
            k <= '0;
        end else begin
            k <= next_k;
        end
    end

    assign mdo     = f.out_sh[7];
    assign mdo_oe  = f.rd_mode;
    assign wr_word = k.word;
    assign wr_tog  = k.wr_tog;
    assign rd_tog  = k.rd_tog;
endmodule // dmc_link

//--- dmc_regs.sv
`timescale 1ns/1ps
module dmc_regs (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    // serial control link
    input  wire logic                    mc_clk,
    input  wire logic                    ml,
    input  wire logic                    mdi,
    output logic                         mdo,
    output logic                         mdo_oe,
    // sample timing
    input  wire logic                    fs_tick,
    // per-channel controls
    output logic [dmc_pkg::NUM_CH-1:0][7:0] applied_level,
    output logic [dmc_pkg::NUM_CH-1:0]   channel_silent,
    output logic [dmc_pkg::NUM_CH-1:0]   channel_off,
    // format, filter and clock output
    output dmc_pkg::dmc_format_t         audio_format,
    output logic                         rolloff_select,
    output logic                         clock_out_divide,
    output logic                         clock_out_disable,
    // de-emphasis and polarity
    output logic                         deemph_enable,
    output logic [1:0]                   deemph_rate,
    output logic                         output_phase_invert,
    output logic                         zero_flag_polarity,
    // oversampling and general outputs
    output logic                         oversample_high,
    output logic                         general_output_enable,
    output logic [5:0]                   general_output_bits
);
    import dmc_pkg::*;

    typedef struct packed {
        logic [NUM_REGS:1][7:0] regs;
        logic [1:0]             ml_sync;
        logic                   ml_prev;
        logic [1:0]             wr_sync;
        logic                   wr_prev;
        logic [1:0]             rq_sync;
        logic                   rq_prev;
        logic [6:0]             rd_ptr;
        logic [7:0]             rd_byte;
        logic [2:0]             fs_cnt;
        logic                   step;
        logic                   deemph;
    } dmc_ctl_t;

    dmc_ctl_t             s;
    dmc_ctl_t             next_s;
    logic [15:0]          wr_word;
    logic                 wr_tog;
    logic                 rd_tog;
    logic                 wr_event;
    logic                 rq_event;
    logic                 frame_start;
    logic [6:0]           wr_idx;
    logic [NUM_CH-1:0][7:0] target;

    // serial shifter on the link clock
    dmc_link u_link (
        .mc_clk  (mc_clk),
        .ml      (ml),
        .rst_b   (rst_b),
        .mdi     (mdi),
        .mdo     (mdo),
        .mdo_oe  (mdo_oe),
        .rd_byte (s.rd_byte),
        .wr_word (wr_word),
        .wr_tog  (wr_tog),
        .rd_tog  (rd_tog)
    );

    // events seen after two synchroniser stages, edge taken on the second
    assign wr_event    = s.wr_sync[1] ^ s.wr_prev;
    assign rq_event    = s.rq_sync[1] ^ s.rq_prev;
    assign frame_start = s.ml_prev & ~s.ml_sync[1];
    assign wr_idx      = wr_word[IDX_MSB:IDX_LSB];

    // byte for a readback index; unmapped indices read zero
    function automatic logic [7:0] read_reg(input logic [NUM_REGS:1][7:0] r, input logic [6:0] idx);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 1; i <= NUM_REGS; i++) begin
            if (idx == 7'(i)) begin
                v = r[i];
            end
        end
        return v;
    endfunction

    // synchronisers, write decode, readback pointer and step divider
    always_comb begin
        next_s         = s;
        next_s.ml_sync = {s.ml_sync[0], ml};
        next_s.ml_prev = s.ml_sync[1];
        next_s.wr_sync = {s.wr_sync[0], wr_tog};
        next_s.wr_prev = s.wr_sync[1];
        next_s.rq_sync = {s.rq_sync[0], rd_tog};
        next_s.rq_prev = s.rq_sync[1];
        // the word is held by the link side since its toggle flipped, so it is stable here
        if (wr_event && !wr_word[RW_POS]) begin
            for (int i = 1; i <= NUM_REGS; i++) begin
                if (wr_idx == 7'(i)) begin
                    next_s.regs[i] = wr_word[7:0];
                end
            end
        end
        // readback starts at the programmed index and, with the increment bit set, advances on each byte request
        if (frame_start) begin
            next_s.rd_ptr  = s.regs[IDX_READBACK][6:0];
            next_s.rd_byte = read_reg(s.regs, s.regs[IDX_READBACK][6:0]);
        end else if (rq_event) begin
            if (s.regs[IDX_READBACK][INC_POS]) begin
                next_s.rd_ptr = (s.rd_ptr >= IDX_LAST) ? IDX_FIRST : s.rd_ptr + 7'h01;
            end
            next_s.rd_byte = read_reg(s.regs, next_s.rd_ptr);
        end
        // one step strobe every eighth sample tick
        next_s.step = 1'b0;
        if (fs_tick) begin
            next_s.fs_cnt = s.fs_cnt + 3'h1;
            next_s.step   = (s.fs_cnt == RAMP_LAST_FS);
        end
        next_s.deemph = |s.regs[IDX_DEEMPH][DMC_MSB:0];
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s                        <= '0;
            s.regs[1]                <= ATTEN_RESET;
            s.regs[2]                <= ATTEN_RESET;
            s.regs[3]                <= ATTEN_RESET;
            s.regs[4]                <= ATTEN_RESET;
            s.regs[5]                <= ATTEN_RESET;
            s.regs[6]                <= ATTEN_RESET;
            s.regs[IDX_MUTE]         <= ZERO_RESET;
            s.regs[IDX_OFF]          <= ZERO_RESET;
            s.regs[IDX_READBACK]     <= READBACK_RESET;
        end else begin
            s <= next_s;
        end
    end

    // per-channel ramp; muted or sub-range codes all aim at the silent code
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        assign target[ch] = (s.regs[IDX_MUTE][ch] || s.regs[ch+1] <= MUTE_CODE)
                            ? MUTE_CODE : s.regs[ch+1];
        dmc_ramp u_ramp (
            .ref_clk (ref_clk),
            .rst_b   (rst_b),
            .step    (s.step),
            .target  (target[ch]),
            .level   (applied_level[ch]),
            .silent  (channel_silent[ch])
        );
    end

    // field outputs straight from the register flops; de-emphasis enable through one more flop
    assign channel_off           = s.regs[IDX_OFF][NUM_CH-1:0];
    assign audio_format          = dmc_format_t'(s.regs[IDX_FORMAT][2:0]);
    assign rolloff_select        = s.regs[IDX_FORMAT][FLT_POS];
    assign clock_out_divide      = s.regs[IDX_FORMAT][CLOCK_OUT_DIVIDE_POS];
    assign clock_out_disable     = s.regs[IDX_FORMAT][CLOCK_OUT_DISABLE_POS];
    assign deemph_enable         = s.deemph;
    assign deemph_rate           = s.regs[IDX_DEEMPH][DMF_MSB:DMF_LSB];
    assign output_phase_invert   = s.regs[IDX_DEEMPH][OUTPUT_PHASE_INVERT_POS];
    assign zero_flag_polarity    = s.regs[IDX_DEEMPH][ZERO_FLAG_POLARITY_POS];
    assign oversample_high       = s.regs[IDX_GPIO][OVER_POS];
    assign general_output_enable = s.regs[IDX_GPIO][GENERAL_OUTPUT_ENABLE_POS];
    assign general_output_bits   = s.regs[IDX_GPIO][5:0];

    // checks on the register side
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_write_lands: assert property (
        (wr_event && !wr_word[RW_POS] && wr_idx == IDX_FIRST) |=> s.regs[1] == $past(wr_word[7:0]))
        else $error("write to index one did not land");

    a_read_no_store: assert property (
        (rq_event && !wr_event) |=> s.regs == $past(s.regs))
        else $error("read byte request changed a register");

    a_bad_index: assert property (
        (wr_event && (wr_idx < IDX_FIRST || wr_idx > IDX_LAST)) |=> $stable(s.regs))
        else $error("out of range write changed a register");

    a_level_floor: assert property (
        channel_silent[0] == (applied_level[0] <= MUTE_CODE) && applied_level[0] >= MUTE_CODE)
        else $error("channel one silence flag or floor wrong");

    a_step_hold: assert property (
        !s.step |=> $stable(applied_level))
        else $error("level moved without a step strobe");

    a_step_spacing: assert property (
        s.step |=> !s.step [*7])
        else $error("step strobes closer than eight ticks");

    a_mute_down: assert property (
        (s.step && s.regs[IDX_MUTE][0] && applied_level[0] > MUTE_CODE)
        |=> applied_level[0] == $past(applied_level[0]) - 8'h01)
        else $error("muted channel did not step down");

    a_unmute_up: assert property (
        (s.step && !s.regs[IDX_MUTE][0] && s.regs[1] > applied_level[0])
        |=> applied_level[0] == $past(applied_level[0]) + 8'h01)
        else $error("unmuted channel did not step up");

    a_off_follows: assert property (
        (wr_event && !wr_word[RW_POS] && wr_idx == 7'(IDX_OFF))
        |=> channel_off == $past(wr_word[NUM_CH-1:0]))
        else $error("channel off bits did not follow write");

    a_deemph_or: assert property (
        ##1 deemph_enable == |$past(s.regs[IDX_DEEMPH][DMC_MSB:0]))
        else $error("de-emphasis enable is not the or of its bits");

    a_read_wrap: assert property (
        (!frame_start && rq_event && s.regs[IDX_READBACK][INC_POS] && s.rd_ptr == IDX_LAST)
        |=> s.rd_ptr == IDX_FIRST)
        else $error("readback pointer did not wrap to one");
endmodule // dmc_regs

//--- dmc_host.sv
`timescale 1ns/1ps
module dmc_host (
    // serial control pins driven by the host
    output logic      mc_clk,
    output logic      ml,
    output logic      mdi,
    // serial data returned by the device
    input  wire logic mdo,
    input  wire logic mdo_oe
);
    logic [7:0] rd_buf [0:15];
    logic       oe_bad;

    // link clock rests low between frames
    initial begin
        mc_clk = 1'b0;
        ml     = 1'b1;
        mdi    = 1'b0;
        oe_bad = 1'b0;
    end

    // one frame: word msb first, n bytes clocked out from the eighth clock on; n of zero is a plain write
    task automatic frame(input logic [15:0] word, input int n);
        int k;
        int last;
        last = (n == 0) ? 16 : 8 + 8 * n;
        oe_bad = 1'b0;
        #1.7 ml = 1'b0;
        #10;
        for (int e = 1; e <= last; e++) begin
            mdi = (e <= 16) ? word[16 - e] : 1'b0;   // direction bit leads, then index and data
            #7.5 mc_clk = 1'b1;
            #7.5 mc_clk = 1'b0;
            k = e - 8;
            // data bits are sampled half a period after the device updates them
            if (n > 0 && k >= 0 && k < 8 * n) begin
                rd_buf[k / 8][7 - k % 8] = mdo;
                if (mdo_oe !== 1'b1) oe_bad = 1'b1;
            end else if (n > 0 && k < 0 && mdo_oe !== 1'b0) begin
                oe_bad = 1'b1;
            end
        end
        #20 ml = 1'b1;
        mdi = ~mdi;   // idle line does not rest on the last bit
        #300;         // frame latch high time before the next frame
    endtask
endmodule // dmc_host

//--- test_dmc_regs.sv
`timescale 1ns/1ps
module test_dmc_regs;
    import dmc_pkg::*;
    logic                   ref_clk = 1'b0;
    logic                   rst_b   = 1'b0;
    logic                   fs_tick = 1'b0;
    logic                   mc_clk, ml, mdi, mdo, mdo_oe;
    logic [NUM_CH-1:0][7:0] applied_level;
    logic [NUM_CH-1:0]      channel_silent, channel_off;
    dmc_format_t            audio_format;
    logic                   rolloff_select, clock_out_divide, clock_out_disable;
    logic                   deemph_enable, output_phase_invert, zero_flag_polarity;
    logic [1:0]             deemph_rate;
    logic                   oversample_high, general_output_enable;
    logic [5:0]             general_output_bits;
    logic [7:0]             shadow [1:12];
    int                     n_fail = 0;
    int                     checks = 0;

    // device under test and the host on its control port
    dmc_regs i_dmc_regs (.ref_clk, .rst_b, .mc_clk, .ml, .mdi, .mdo, .mdo_oe, .fs_tick, .applied_level,
        .channel_silent, .channel_off, .audio_format, .rolloff_select, .clock_out_divide, .clock_out_disable,
        .deemph_enable, .deemph_rate, .output_phase_invert, .zero_flag_polarity, .oversample_high,
        .general_output_enable, .general_output_bits);
    dmc_host i_dmc_host (.mc_clk, .ml, .mdi, .mdo, .mdo_oe);

    // system clock
    always #2 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s: got %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // write one word; only mapped indices, never index zero, reach the shadow
    task automatic wr(input logic [6:0] idx, input logic [7:0] data);
        i_dmc_host.frame({1'b0, idx, data}, 0);
        if (idx >= IDX_FIRST && idx <= IDX_LAST) shadow[idx] = data;
        repeat (2) @(posedge ref_clk);
    endtask

    // sample ticks two cycles apart; callers keep counts a multiple of eight
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk) fs_tick <= 1'b1;
            @(posedge ref_clk) fs_tick <= 1'b0;
        end
        repeat (3) @(posedge ref_clk);
    endtask

    // auto-increment read of all twelve registers plus one wrapped byte
    task automatic check_all();
        wr(7'h0B, 8'h81);
        i_dmc_host.frame(16'h8000, 13);
        for (int r = 1; r <= 13; r++) begin
            check(16'(i_dmc_host.rd_buf[r-1]), 16'(shadow[(r-1)%12+1]), "readback");
        end
        check(16'(i_dmc_host.oe_bad), 16'h0000, "mdo_oe");
    endtask

    task automatic t_reset();
        for (int c = 0; c < 6; c++) check(16'(applied_level[c]), 16'h00FF, "level");
        check(16'(channel_silent), 16'h0000, "silent");
        check(16'(channel_off), 16'h0000, "off");
        check(16'(audio_format), 16'h0000, "format");
        i_dmc_host.frame(16'h8000, 2);
        check(16'(i_dmc_host.rd_buf[0]), 16'h00FF, "rd0");
        check(16'(i_dmc_host.rd_buf[1]), 16'h00FF, "rd1");
        check_all();
    endtask

    task automatic t_fields();
        logic [2:0] f;
        for (int i = 0; i < 6; i++) begin
            f = 3'(i);
            wr(7'h09, {2'b00, f, f});
            check(16'(audio_format), 16'(f), "format");
            check(16'({rolloff_select, clock_out_divide, clock_out_disable}), 16'(f), "reg9");
        end
        for (int i = 0; i < 8; i++) begin
            f = 3'(i);
            wr(7'h0A, {1'b0, f[0], f[1], f[1:0], f});
            check(16'(deemph_enable), 16'(|f), "deemph");
            check(16'({zero_flag_polarity, output_phase_invert, deemph_rate}), 16'({f[0], f[1], f[1:0]}), "reg10");
        end
        wr(7'h08, 8'h2A);
        check(16'(channel_off), 16'h002A, "off");
        wr(7'h0C, 8'hC5);
        check(16'({oversample_high, general_output_enable, general_output_bits}), 16'h00C5, "reg12");
        check_all();
    endtask

    task automatic t_refused();
        wr(7'h0D, 8'h55);
        wr(7'h7F, 8'hAA);
        i_dmc_host.frame(16'h8033, 1);
        check_all();
        check(16'(audio_format), 16'h0005, "format kept");
    endtask

    task automatic t_ramp();
        wr(7'h01, 8'hFC);
        wr(7'h02, 8'h05);
        for (int i = 1; i <= 3; i++) begin
            tick(8);
            check(16'(applied_level[0]), 16'(255 - i), "ramp1");
            check(16'(applied_level[1]), 16'(255 - i), "ramp2");
        end
        tick(24);
        check(16'(applied_level[0]), 16'h00FC, "hold");
        wr(7'h07, 8'h01);
        wr(7'h01, 8'hFA);
        tick(8);
        check(16'(applied_level[0]), 16'h00FB, "mute step");
        tick(8 * 123);
        check(16'(applied_level[0]), 16'h0080, "muted");
        check(16'(applied_level[1]), 16'h0080, "low code");
        check(16'(channel_silent), 16'h0003, "silent");
        wr(7'h07, 8'h00);
        tick(8);
        check(16'(applied_level[0]), 16'h0081, "unmute step");
        check(16'(channel_silent), 16'h0002, "audible");
        tick(8 * 121);
        check(16'(applied_level[0]), 16'h00FA, "unmuted");
        check(16'(applied_level[5]), 16'h00FF, "ch6");
    endtask

    // reset, then the scenarios in turn
    initial begin
        shadow = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_fields();
        t_refused();
        t_ramp();
        print_verdict();
    end

    // watchdog well beyond the expected run of about 40 us
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
endmodule // test_dmc_regs
